// ==== pcur_device_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcur_device_regs
    import pcur_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              reset_in,
    input  wire pcur_cfg_req_s     cfg_req_in,
    output logic [31:0]            cfg_rdata_out,
    output logic                   cfg_rvalid_out,
    input  wire logic              power_msg_valid_in,
    input  wire logic [MSG_W-1:0]  power_msg_payload_in,
    output pcur_power_s            power_limit_out,
    output logic [2:0]             read_request_limit_out,
    output logic [2:0]             max_payload_size_out
);

    // Control register fields, each in its own flip-flop group
    logic [2:0]   read_request_limit_r;
    logic [2:0]   read_request_limit_nxt;
    logic [2:0]   max_payload_size_r;
    logic [2:0]   max_payload_size_nxt;

    // Read answer
    logic [31:0]  rdata_r;
    logic [31:0]  rdata_nxt;
    logic         rvalid_r;
    logic         rvalid_nxt;

    // Per-field write enables
    logic         rrl_we;
    logic         mps_we;

    // Register images as they read back
    logic [31:0]  cap_image;
    logic [31:0]  ctrl_image;

    // Which register a read request selects
    typedef enum logic [1:0] {
        PCUR_RD_NONE,
        PCUR_RD_CAP,
        PCUR_RD_CTRL,
        PCUR_RD_UNMAPPED
    } pcur_rd_sel_e;

    // Which register a write request selects
    typedef enum logic [1:0] {
        PCUR_WR_NONE,
        PCUR_WR_CAP,
        PCUR_WR_CTRL,
        PCUR_WR_UNMAPPED
    } pcur_wr_sel_e;

    pcur_rd_sel_e rd_sel;
    pcur_wr_sel_e wr_sel;

    function automatic logic addr_hit(input logic [CFG_ADDR_W-1:0] addr,
                                      input logic [CFG_ADDR_W-1:0] ofs);
        return addr == ofs;
    endfunction

    function automatic logic lane_on(input logic [3:0] be,
                                     input int         lane);
        return be[lane];
    endfunction

    function automatic logic [2:0] rrl_field(input logic [31:0] wd);
        return wd[CTRL_RRL_HI:CTRL_RRL_LO];
    endfunction

    function automatic logic [2:0] mps_field(input logic [31:0] wd);
        return wd[CTRL_MPS_HI:CTRL_MPS_LO];
    endfunction

    // Only reads produce an answer; the address picks the source
    function automatic pcur_rd_sel_e rd_target(input pcur_cfg_req_s req);
        pcur_rd_sel_e sel;
        if (!req.valid || req.write) begin
            sel = PCUR_RD_NONE;
        end else if (addr_hit(req.addr, DEV_CAP_OFS)) begin
            sel = PCUR_RD_CAP;
        end else if (addr_hit(req.addr, DEV_CTRL_OFS)) begin
            sel = PCUR_RD_CTRL;
        end else begin
            sel = PCUR_RD_UNMAPPED;
        end
        return sel;
    endfunction

    // Only writes to the control register carry any effect
    function automatic pcur_wr_sel_e wr_target(input pcur_cfg_req_s req);
        pcur_wr_sel_e sel;
        if (!req.valid || !req.write) begin
            sel = PCUR_WR_NONE;
        end else if (addr_hit(req.addr, DEV_CAP_OFS)) begin
            sel = PCUR_WR_CAP;
        end else if (addr_hit(req.addr, DEV_CTRL_OFS)) begin
            sel = PCUR_WR_CTRL;
        end else begin
            sel = PCUR_WR_UNMAPPED;
        end
        return sel;
    endfunction

    function automatic logic [31:0] cap_word(input pcur_power_s p);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CAP_SCALE_HI:CAP_SCALE_LO] = p.scale;
        w[CAP_VALUE_HI:CAP_VALUE_LO] = p.value;
        w[CAP_ROLE_ERR] = ROLE_ERROR_REPORT_SUPPORT;
        w[CAP_WIDE_TAG] = WIDE_TAG_SUPPORT;
        w[CAP_GHOST_HI:CAP_GHOST_LO] = GHOST_FUNCTION_SUPPORT;
        w[CAP_MPS_HI:CAP_MPS_LO] = MAX_PAYLOAD_SUPPORTED;
        return w;
    endfunction

    function automatic logic [31:0] ctrl_word(input logic [2:0] rrl,
                                              input logic [2:0] mps);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[CTRL_RRL_HI:CTRL_RRL_LO] = rrl;
        w[CTRL_MPS_HI:CTRL_MPS_LO] = mps;
        return w;
    endfunction

    // Only the message path may load the captured power fields
    pcur_power_capture u_capture (
        .clock_in   (clock_in),
        .reset_in   (reset_in),
        .load_in    (power_msg_valid_in),
        .payload_in (power_msg_payload_in),
        .power_out  (power_limit_out)
    );

    always_comb begin
        wr_sel = wr_target(cfg_req_in);
    end

    // Writes to the capabilities word or an unmapped address are dropped,
    // so the captured power fields move on messages alone
    always_comb begin
        rrl_we = 1'h0;
        mps_we = 1'h0;
        unique case (wr_sel)
            PCUR_WR_CTRL: begin
                rrl_we = lane_on(cfg_req_in.byte_en, BE_RRL);
                mps_we = lane_on(cfg_req_in.byte_en, BE_MPS);
            end
            PCUR_WR_CAP: begin
                rrl_we = 1'h0;
                mps_we = 1'h0;
            end
            PCUR_WR_UNMAPPED, PCUR_WR_NONE: begin
                rrl_we = 1'h0;
                mps_we = 1'h0;
            end
        endcase
    end

    always_comb begin
        read_request_limit_nxt = read_request_limit_r;
        if (rrl_we) begin
            read_request_limit_nxt = rrl_field(cfg_req_in.wdata);
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            read_request_limit_r <= RRL_RESET;
        end else begin
            read_request_limit_r <= read_request_limit_nxt;
        end
    end

    // Reserved payload size encodings are kept as written
    always_comb begin
        max_payload_size_nxt = max_payload_size_r;
        if (mps_we) begin
            max_payload_size_nxt = mps_field(cfg_req_in.wdata);
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            max_payload_size_r <= MPS_RESET;
        end else begin
            max_payload_size_r <= max_payload_size_nxt;
        end
    end

    assign cap_image  = cap_word(power_limit_out);
    assign ctrl_image = ctrl_word(read_request_limit_r, max_payload_size_r);

    always_comb begin
        rd_sel = rd_target(cfg_req_in);
    end

    // Read data hold until the next read; unmapped reads answer zero
    // rather than stale data
    always_comb begin
        rdata_nxt = rdata_r;
        unique case (rd_sel)
            PCUR_RD_CAP: begin
                rdata_nxt = cap_image;
            end
            PCUR_RD_CTRL: begin
                rdata_nxt = ctrl_image;
            end
            PCUR_RD_UNMAPPED: begin
                rdata_nxt = 32'h0000_0000;
            end
            PCUR_RD_NONE: begin
                rdata_nxt = rdata_r;
            end
        endcase
    end

    // Answer marker follows the request by exactly one cycle
    always_comb begin
        rvalid_nxt = (rd_sel != PCUR_RD_NONE);
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            rvalid_r <= 1'h0;
        end else begin
            rvalid_r <= rvalid_nxt;
        end
    end

    assign cfg_rdata_out          = rdata_r;
    assign cfg_rvalid_out         = rvalid_r;
    assign read_request_limit_out = read_request_limit_r;
    assign max_payload_size_out   = max_payload_size_r;

endmodule
`default_nettype wire

// ==== pcur_pkg.sv ====
`default_nettype none
package pcur_pkg;

    localparam int CFG_ADDR_W = 12;

    localparam logic [CFG_ADDR_W-1:0] DEV_CAP_OFS  = 12'h094;
    localparam logic [CFG_ADDR_W-1:0] DEV_CTRL_OFS = 12'h098;

    // Capabilities word layout
    localparam int CAP_SCALE_HI = 27;
    localparam int CAP_SCALE_LO = 26;
    localparam int CAP_VALUE_HI = 25;
    localparam int CAP_VALUE_LO = 18;
    localparam int CAP_ROLE_ERR = 15;
    localparam int CAP_WIDE_TAG = 5;
    localparam int CAP_GHOST_HI = 4;
    localparam int CAP_GHOST_LO = 3;
    localparam int CAP_MPS_HI   = 2;
    localparam int CAP_MPS_LO   = 0;

    localparam logic       ROLE_ERROR_REPORT_SUPPORT = 1'h1;
    localparam logic       WIDE_TAG_SUPPORT          = 1'h0;
    localparam logic [1:0] GHOST_FUNCTION_SUPPORT    = 2'h0;
    localparam logic [2:0] MAX_PAYLOAD_SUPPORTED     = 3'h1;

    // Power limit message payload layout
    localparam int MSG_W        = 10;
    localparam int MSG_SCALE_HI = 9;
    localparam int MSG_SCALE_LO = 8;
    localparam int MSG_VALUE_HI = 7;
    localparam int MSG_VALUE_LO = 0;

    // Device control layout
    localparam int CTRL_W     = 16;
    localparam int CTRL_RRL_HI = 14;
    localparam int CTRL_RRL_LO = 12;
    localparam int CTRL_MPS_HI = 7;
    localparam int CTRL_MPS_LO = 5;
    localparam int BE_RRL      = 1;
    localparam int BE_MPS      = 0;

    localparam logic [CTRL_W-1:0] DEV_CTRL_RESET = 16'h2000;
    localparam logic [2:0] RRL_RESET = DEV_CTRL_RESET[CTRL_RRL_HI:CTRL_RRL_LO];
    localparam logic [2:0] MPS_RESET = DEV_CTRL_RESET[CTRL_MPS_HI:CTRL_MPS_LO];

    // Power scale multiplier codes
    typedef enum logic [1:0] {
        PCUR_SCALE_1_0   = 2'h0,
        PCUR_SCALE_0_1   = 2'h1,
        PCUR_SCALE_0_01  = 2'h2,
        PCUR_SCALE_0_001 = 2'h3
    } pcur_scale_e;

    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic [CFG_ADDR_W-1:0] addr;
        logic [3:0]            byte_en;
        logic [31:0]           wdata;
    } pcur_cfg_req_s;

    typedef struct packed {
        pcur_scale_e scale;
        logic [7:0]  value;
    } pcur_power_s;

endpackage
`default_nettype wire

// ==== pcur_power_capture.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcur_power_capture
    import pcur_pkg::*;
(
    input  wire logic              clock_in,
    input  wire logic              reset_in,
    input  wire logic              load_in,
    input  wire logic [MSG_W-1:0]  payload_in,
    output var  pcur_power_s       power_out
);

    // One register holds both fields so they never disagree
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            power_out <= '{scale: PCUR_SCALE_1_0, value: 8'h00};
        end else if (load_in) begin
            power_out.scale <= pcur_scale_e'(
                payload_in[MSG_SCALE_HI:MSG_SCALE_LO]);
            power_out.value <= payload_in[MSG_VALUE_HI:MSG_VALUE_LO];
        end
    end

endmodule
`default_nettype wire

// ==== pcur_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcur_chk
    import pcur_pkg::*;
(
    input wire logic          clock_in,
    input wire logic          reset_in,
    input wire pcur_cfg_req_s cfg_req_in,
    input wire logic [31:0]   cfg_rdata_out,
    input wire logic          cfg_rvalid_out,
    input wire logic          power_msg_valid_in,
    input wire logic [9:0]    power_msg_payload_in,
    input wire pcur_power_s   power_limit_out,
    input wire logic [2:0]    read_request_limit_out,
    input wire logic [2:0]    max_payload_size_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    wire logic rd = cfg_req_in.valid && !cfg_req_in.write;
    wire logic wr = cfg_req_in.valid && cfg_req_in.write;
    sequence s_cap; rd && cfg_req_in.addr == DEV_CAP_OFS ##1 1; endsequence
    sequence s_ctl; rd && cfg_req_in.addr == DEV_CTRL_OFS ##1 1; endsequence
    property p_pair;
        power_msg_valid_in |=> power_limit_out == $past(power_msg_payload_in);
    endproperty
    property p_hold; !power_msg_valid_in |=> $stable(power_limit_out); endproperty
    property p_capfld;
        s_cap |-> cfg_rdata_out[27:18] == $past(power_limit_out);
    endproperty
    property p_fixed; s_cap |-> cfg_rdata_out[15:0] == 16'h8001; endproperty
    property p_rsvd;
        s_cap |-> cfg_rdata_out[31:28] == 4'h0 && cfg_rdata_out[17:16] == 2'h0;
    endproperty
    property p_rrl;
        wr && cfg_req_in.addr == DEV_CTRL_OFS && cfg_req_in.byte_en[1]
            |=> read_request_limit_out == $past(cfg_req_in.wdata[14:12]);
    endproperty
    property p_ctrl;
        s_ctl |-> cfg_rdata_out == {17'h0, $past(read_request_limit_out), 4'h0,
            $past(max_payload_size_out), 5'h0};
    endproperty
    property p_rv; cfg_rvalid_out |-> $past(rd); endproperty
    a_pair: assert property (p_pair) else $error("pair");
    a_hold: assert property (p_hold) else $error("hold");
    a_capfld: assert property (p_capfld)
        else $error("capfld");
    a_fixed: assert property (p_fixed)
        else $error("fixed");
    a_rsvd: assert property (p_rsvd) else $error("rsvd");
    a_rrl: assert property (p_rrl) else $error("rrl");
    a_ctrl: assert property (p_ctrl) else $error("ctrl");
    a_rv: assert property (p_rv) else $error("rvalid");
endmodule
bind pcur_device_regs pcur_chk i_chk (.clock_in, .reset_in, .cfg_req_in,
    .cfg_rdata_out, .cfg_rvalid_out, .power_msg_valid_in, .power_msg_payload_in,
    .power_limit_out, .read_request_limit_out, .max_payload_size_out);
`default_nettype wire

// ==== pcur_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcur_host_model
    import pcur_pkg::*;
(
    input  wire logic             clock_in,
    output var  logic             msg_valid_out,
    output var  logic [MSG_W-1:0] msg_payload_out
);
    initial msg_valid_out = 1'h0;
    initial msg_payload_out = 10'h155;
    // One pulse carries scale and value together; payload garbled after
    task automatic send(input logic [MSG_W-1:0] p);
        @(posedge clock_in) #1;
        msg_valid_out = 1'h1;
        msg_payload_out = p;
        @(posedge clock_in) #1;
        msg_valid_out = 1'h0;
        msg_payload_out = ~p;
    endtask
endmodule
`default_nettype wire

// ==== pcie_upstream_device_capability_regs_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module pcie_upstream_device_capability_regs_test;
    import pcur_pkg::*;
    logic clock_in = 1'h0, reset_in = 1'h1, rvalid, mv;
    logic [9:0] mp;
    logic [2:0] rrl, mps;
    logic [31:0] rdata, d, exp_q[$];
    pcur_cfg_req_s cfg = '0;
    pcur_power_s pl;
    int error_cnt = 0, num_checks = 0, seed = 83123, k;
    always #2 clock_in = ~clock_in;
    pcur_host_model i_host (.clock_in(clock_in), .msg_valid_out(mv),
        .msg_payload_out(mp));
    pcur_device_regs i_dut (.clock_in(clock_in), .reset_in(reset_in),
        .cfg_req_in(cfg), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
        .power_msg_valid_in(mv), .power_msg_payload_in(mp),
        .power_limit_out(pl), .read_request_limit_out(rrl),
        .max_payload_size_out(mps));
    task automatic chk(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [11:0] a,
        input logic [3:0] be, input logic [31:0] wd, ex);
        @(posedge clock_in) #1;
        cfg = {1'h1, w, a, be, wd};
        if (!w) exp_q.push_back(ex);
        @(posedge clock_in) #1;
        cfg.valid = 1'h0;
    endtask
    task automatic drain(input string name);
        for (k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge clock_in);
        if (exp_q.size() > 0) begin
            error_cnt++;
            report_and_stop();
        end else
            $display("test %s done", name);
    endtask
    always @(negedge clock_in) begin
        if (rvalid === 1'h1)
            chk(rdata,
                exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);
    end
    initial begin
        repeat (20) @(posedge clock_in);
        #1 reset_in = 1'h0;
        chk({26'h0, rrl, mps}, 32'h10);
        acc(0, DEV_CAP_OFS, 4'hf, 0, 32'h8001);
        acc(0, DEV_CTRL_OFS, 4'hf, 0, 32'h2000);
        acc(0, 12'h0a0, 4'hf, 0, 0);
        drain("reset");
        for (int s = 0; s < 4; s++) begin
            d = $random(seed);
            i_host.send({s[1:0], d[7:0]});
            chk({22'h0, pl}, {22'h0, s[1:0], d[7:0]});
            acc(1, DEV_CAP_OFS, 4'hf, $random(seed), 0);
            acc(0, DEV_CAP_OFS, 4'hf, 0,
                {4'h0, s[1:0], d[7:0], 18'h08001});
        end
        drain("power");
        for (int c = 0; c < 8; c++) begin
            d = $random(seed);
            d[14:12] = c[2:0];
            acc(1, DEV_CTRL_OFS, 4'h3, d, 0);
            chk({29'h0, rrl}, {29'h0, c[2:0]});
            chk({29'h0, mps}, {29'h0, d[7:5]});
            acc(0, DEV_CTRL_OFS, 4'hf, 0,
                {17'h0, d[14:12], 4'h0, d[7:5], 5'h0});
        end
        acc(1, DEV_CTRL_OFS, 4'h0, 32'hffffffff, 0);
        chk({29'h0, rrl}, {29'h0, d[14:12]});
        chk({29'h0, mps}, {29'h0, d[7:5]});
        drain("control");
        @(posedge clock_in) #1;
        reset_in = 1'h1;
        repeat (3) @(posedge clock_in);
        #1 reset_in = 1'h0;
        chk({22'h0, pl}, 32'h0);
        chk({26'h0, rrl, mps}, 32'h10);
        acc(0, DEV_CAP_OFS, 4'hf, 0, 32'h8001);
        acc(0, DEV_CTRL_OFS, 4'hf, 0, 32'h2000);
        drain("reset again");
        report_and_stop();
    end
endmodule
`default_nettype wire
